/* File: logic/dac_latch_defs.svh */
// constants for the parallel input latch
`ifndef DAC_LATCH_DEFS_SVH
`define DAC_LATCH_DEFS_SVH
`define CODE_WIDTH      14
`define CODE_MAX        14'h3FFF
`define CODE_ZERO       14'h0000
`define MSB_POS         13
`define LSB_POS         0
`define CLOCK_MHZ       100
`define MAX_RATE_MSPS   125
`define BUF_DEPTH       2
`define MIN_GAP_COUNT   4'h2
`define GAP_LIMIT       4'hF
`endif

/* File: logic/dac_latch_pkg.sv */
// types shared by the input latch modules
package dac_latch_pkg;
   typedef logic [13:0] code_t;
   typedef enum logic [0:0] {
      mode_active,
      mode_sleep
   } power_mode_t;
endpackage

/* File: logic/sample_buf_if.sv */
// interface carrying words through the sample buffer
`timescale 1ns/1ps
interface sample_buf_if #(parameter int W = 14);
   logic         in_valid;
   logic         in_ready;
   logic [W-1:0] in_data;
   logic         out_valid;
   logic         out_ready;
   logic [W-1:0] out_data;
   modport buf_side (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
   modport user_side (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface

/* File: logic/sample_buf.sv */
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module sample_buf #(
   parameter int W = 14
) (
   input wire logic    clock,
   input wire logic    rstn,
   sample_buf_if.buf_side bus
);
   logic [W-1:0] slot [2];
   logic         rd_ptr;
   logic         wr_ptr;
   logic [1:0]   count;
   logic         push;
   logic         pop;

   assign push          = bus.in_valid && (count != 2'h2);
   assign pop           = (count != 2'h0) && bus.out_ready;
   assign bus.in_ready  = (count != 2'h2);
   assign bus.out_valid = (count != 2'h0);
   assign bus.out_data  = slot[rd_ptr];

   always_ff @(posedge clock) begin
      if (push) begin
         slot[wr_ptr] <= bus.in_data;
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         rd_ptr <= 1'b0;
         wr_ptr <= 1'b0;
         count  <= 2'h0;
      end else begin
         if (push) begin
            wr_ptr <= ~wr_ptr;
         end
         if (pop) begin
            rd_ptr <= ~rd_ptr;
         end
         count <= count + {1'b0, push} - {1'b0, pop};
      end
   end

   a_buf_no_overflow: assert property (@(posedge clock) disable iff (!rstn)
      count <= 2'h2) else $error("buffer count above two");
endmodule // sample_buf

/* File: logic/dac_parallel_input_latch.sv */
// digital front end of a 14-bit current-output converter
//
// What this block does
// [R01] the interface is a 14-bit parallel word plus one sample clock, all bits driven together.
// [R02] the word is unsigned straight binary with bit 13 most and bit 0 least significant.
// [R03] an all-ones code drives full scale on the true output, the complement output carrying the rest.
// [R04] at code 16383 the complement carries nothing; true follows code, complement follows max minus code.
// [R05] the word is captured edge-triggered and the output changes only after a rising sample clock edge or on entering sleep.
// [R06] the path takes rising sample edges at least three 100 MHz clocks apart, about 33 MSPS, and the source must not update faster.
// [R07] any sample clock duty cycle works provided both phases meet the minimum pulse width.
// [R08] the source should change data on the falling edge of a 50% duty clock; the bench source runs 40 ns high and 80 ns low.
// [R09] the sleep input has a pull-down so an unconnected pin leaves the device enabled.
// [R10] sleep at 1 powers down and turns off output current, sleep at 0 restores operation.
// [R11] between rising sample edges the latched code stays constant; the output changes only when a word is accepted from the buffer or in sleep.
`timescale 1ns/1ps
`include "dac_latch_defs.svh"
module dac_parallel_input_latch
   import dac_latch_pkg::*;
#(
   parameter int W = `CODE_WIDTH
) (
   input  wire logic         clock,
   input  wire logic         rstn,
   input  wire logic         sample_clk,
   input  wire logic [W-1:0] sample_word,
   input  wire logic         sleep_pin,
   input  wire logic         sleep_driven,
   input  wire logic         out_ready,
   output logic              out_valid,
   output logic [W-1:0]      true_current_out,
   output logic [W-1:0]      complement_current_out,
   output logic              powered_down,
   output logic              word_dropped
);
   logic [2:0]   clk_sync;
   logic [W-1:0] word_s1;
   logic [W-1:0] word_s2;
   logic [1:0]   sleep_sync;
   logic [1:0]   driven_sync;
   logic         sleep_level;
   logic         rise;
   logic         accept;
   logic [3:0]   gap;
   power_mode_t  mode;
   logic [W-1:0] held_code;
   logic         pending;

   sample_buf_if #(.W(W)) sbus ();

   function automatic logic [W-1:0] complement_of(input logic [W-1:0] code);
      complement_of = W'(`CODE_MAX) - code; // [R04]
   endfunction

   // two-flop synchronisers on every pin input
   always_ff @(posedge clock) begin
      clk_sync <= {clk_sync[1:0], sample_clk};
   end

   always_ff @(posedge clock) begin
      word_s1 <= sample_word; // [R01]
      word_s2 <= word_s1;
   end

   always_ff @(posedge clock) begin
      sleep_sync  <= {sleep_sync[0], sleep_pin};
      driven_sync <= {driven_sync[0], sleep_driven};
   end

   // pull-down: an undriven pin reads as low
   assign sleep_level = driven_sync[1] & sleep_sync[1]; // [R09]

   // rising sample edge, aligned with word_s2
   assign rise   = clk_sync[1] & ~clk_sync[2]; // [R05] [R07]
   assign accept = sbus.out_valid && out_ready;

   // clocks since the last rising sample edge, saturating
   always_ff @(posedge clock) begin
      if (!rstn) begin
         gap <= `GAP_LIMIT;
      end else if (rise) begin
         gap <= 4'h0;
      end else if (gap != `GAP_LIMIT) begin
         gap <= gap + 4'h1;
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         mode <= mode_active;
      end else begin
         mode <= sleep_level ? mode_sleep : mode_active; // [R10]
      end
   end

   // master stage: capture only on the rising edge
   always_ff @(posedge clock) begin
      if (!rstn) begin
         held_code <= `CODE_ZERO;
      end else if (rise) begin
         held_code <= word_s2; // [R05] [R11]
      end
   end

   // one push request per captured word
   always_ff @(posedge clock) begin
      if (!rstn) begin
         pending <= 1'b0;
      end else begin
         pending <= rise;
      end
   end

   assign sbus.in_valid  = pending;
   assign sbus.in_data   = held_code;
   assign sbus.out_ready = out_ready;

   sample_buf #(.W(W)) u_buf (
      .clock (clock),
      .rstn  (rstn),
      .bus   (sbus)
   );

   always_ff @(posedge clock) begin
      if (!rstn) begin
         powered_down <= 1'b0;
      end else begin
         powered_down <= (mode == mode_sleep); // [R10]
      end
   end

   // a capture that finds the buffer full is lost and flagged
   always_ff @(posedge clock) begin
      if (!rstn) begin
         word_dropped <= 1'b0;
      end else begin
         word_dropped <= pending && !sbus.in_ready; // [R06]
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         out_valid <= 1'b0;
      end else begin
         out_valid <= accept; // [R05]
      end
   end

   // slave stage: drive the outputs from the buffer head
   always_ff @(posedge clock) begin
      if (!rstn) begin
         true_current_out       <= `CODE_ZERO;
         complement_current_out <= `CODE_ZERO;
      end else if (mode == mode_sleep) begin
         true_current_out       <= `CODE_ZERO; // [R10]
         complement_current_out <= `CODE_ZERO;
      end else if (accept) begin
         true_current_out       <= sbus.out_data; // [R02] [R03]
         complement_current_out <= complement_of(sbus.out_data); // [R03] [R04]
      end
   end

   a_sum_full_scale: assert property (@(posedge clock) disable iff (!rstn) // [R04]
      (mode == mode_active && accept) |=>
      (true_current_out + complement_current_out == W'(`CODE_MAX)))
      else $error("outputs do not sum to full scale");
   a_comp_from_head: assert property (@(posedge clock) disable iff (!rstn) // [R04]
      (mode == mode_active && accept) |=> (complement_current_out == W'(`CODE_MAX) - $past(sbus.out_data)))
      else $error("complement not max minus code");
   a_max_code_zero: assert property (@(posedge clock) disable iff (!rstn) // [R03]
      (true_current_out == W'(`CODE_MAX) && !powered_down) |-> complement_current_out == `CODE_ZERO)
      else $error("complement nonzero at max code");

   a_sleep_off: assert property (@(posedge clock) disable iff (!rstn) // [R10]
      (mode == mode_sleep) |=> (true_current_out == `CODE_ZERO && complement_current_out == `CODE_ZERO))
      else $error("current on in sleep");
   a_power_flag: assert property (@(posedge clock) disable iff (!rstn) // [R10]
      (mode == mode_sleep) |=> powered_down)
      else $error("power down not flagged");
   a_off_when_down: assert property (@(posedge clock) disable iff (!rstn) // [R10]
      powered_down |-> (true_current_out == `CODE_ZERO && complement_current_out == `CODE_ZERO))
      else $error("current on while flagged down");
   a_sleep_follow: assert property (@(posedge clock) disable iff (!rstn) // [R09]
      sleep_level |=> (mode == mode_sleep))
      else $error("sleep not followed");
   a_wake_follow: assert property (@(posedge clock) disable iff (!rstn) // [R10]
      !sleep_level |=> (mode == mode_active))
      else $error("wake not followed");

   a_hold_between: assert property (@(posedge clock) disable iff (!rstn) // [R11]
      (!rise) |=> $stable(held_code))
      else $error("code changed without rising edge");
   a_edge_capture: assert property (@(posedge clock) disable iff (!rstn) // [R05]
      rise |=> (held_code == $past(word_s2)))
      else $error("word not captured on edge");
   a_out_from_head: assert property (@(posedge clock) disable iff (!rstn) // [R02]
      (mode == mode_active && accept) |=> (true_current_out == $past(sbus.out_data)))
      else $error("output not taken from buffer head");
   a_out_change: assert property (@(posedge clock) disable iff (!rstn) // [R05]
      (mode == mode_active && !accept) |=> $stable(true_current_out))
      else $error("output changed without word");
   a_valid_pulse: assert property (@(posedge clock) disable iff (!rstn) // [R05]
      accept |=> out_valid)
      else $error("update not flagged");
   a_no_update: assert property (@(posedge clock) disable iff (!rstn) // [R05]
      !accept |=> !out_valid)
      else $error("update flagged without word");

   a_pending_pulse: assert property (@(posedge clock) disable iff (!rstn) // [R06]
      rise |=> pending ##1 !pending)
      else $error("capture pulse wrong");
   a_drop_flag: assert property (@(posedge clock) disable iff (!rstn) // [R06]
      (pending && !sbus.in_ready) |=> word_dropped)
      else $error("lost word not flagged");
   a_drop_only_full: assert property (@(posedge clock) disable iff (!rstn) // [R06]
      word_dropped |-> ($past(pending) && !$past(sbus.in_ready)))
      else $error("drop flagged with room left");
   a_rise_spacing: assert property (@(posedge clock) disable iff (!rstn) // [R06]
      rise |-> (gap >= `MIN_GAP_COUNT))
      else $error("sample edges too close");

   c_full: cover property (@(posedge clock) !sbus.in_ready);
   c_max: cover property (@(posedge clock) true_current_out == W'(`CODE_MAX));
   c_sleep: cover property (@(posedge clock) $rose(powered_down));
   c_drop: cover property (@(posedge clock) word_dropped);
   c_wake: cover property (@(posedge clock) $fell(powered_down));
endmodule // dac_parallel_input_latch

/* File: dv/sample_source.sv */
// partner model: parallel sample word and sample clock source
`timescale 1ns/1ps
module sample_source
   import dac_latch_pkg::*;
(
   output logic  sample_clk,
   output code_t sample_word
);
   initial begin
      sample_clk = 1'b0;
      sample_word = 14'h0000;
   end
   // one word per frame, 120 ns apart, clock idle low between frames
   task automatic send(input code_t code);
      sample_word = code;
      #40 sample_clk = 1'b1;
      #40 sample_clk = 1'b0;
      sample_word = ~code;
      #40;
   endtask
endmodule // sample_source

/* File: dv/testbench.sv */
// self-checking bench for the parallel input latch
`timescale 1ns/1ps
module testbench
   import dac_latch_pkg::*;
;
   logic  clock = 1'b0;
   logic  rstn = 1'b0;
   logic  sleep_pin = 1'b0;
   logic  sleep_driven = 1'b1;
   logic  out_ready = 1'b1;
   logic  out_valid, powered_down, word_dropped, sample_clk;
   code_t sample_word, true_current_out, complement_current_out;
   int    err_count = 0;
   int    samples_checked = 0;
   int    drops = 0;
   code_t codes [5] = '{14'h0000, 14'h3FFF, 14'h2000, 14'h0001, 14'h1555};
   always #5 clock = ~clock;
   always @(negedge clock) if (word_dropped === 1'b1) drops++;
   sample_source i_sample_source (.sample_clk(sample_clk), .sample_word(sample_word));
   dac_parallel_input_latch i_dac_parallel_input_latch (
      .clock(clock), .rstn(rstn), .sample_clk(sample_clk), .sample_word(sample_word),
      .sleep_pin(sleep_pin), .sleep_driven(sleep_driven), .out_ready(out_ready),
      .out_valid(out_valid), .true_current_out(true_current_out),
      .complement_current_out(complement_current_out), .powered_down(powered_down),
      .word_dropped(word_dropped));
   task automatic check(input string name, input code_t seen, input code_t exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // one word through; outputs looked at again after the source moved on
   task automatic xfer(input code_t code);
      int n;
      n = 0;
      fork
         i_sample_source.send(code);
         while (out_valid !== 1'b1 && n < 20) begin
            @(negedge clock);
            n++;
         end
      join
      repeat (6) @(negedge clock);
      check("valid_seen", code_t'(n < 20), 14'h0001);
      check("true_out", true_current_out, code);
      check("comp_out", complement_current_out, 14'h3FFF - code);
   endtask
   task automatic test_stall();
      int got;
      got = 0;
      drops = 0;
      out_ready = 1'b0;
      i_sample_source.send(14'h0ABC);
      i_sample_source.send(14'h1DEF);
      i_sample_source.send(14'h2F00);
      repeat (6) @(negedge clock);
      check("drops", code_t'(drops), 14'h0001);
      out_ready = 1'b1;
      repeat (20) begin
         @(negedge clock);
         if (out_valid === 1'b1) begin
            got++;
            check("drain", true_current_out, got == 1 ? 14'h0ABC : 14'h1DEF);
         end
      end
      check("drained", code_t'(got), 14'h0002);
   endtask
   task automatic test_sleep();
      sleep_pin = 1'b1;
      repeat (8) @(negedge clock);
      check("down", code_t'(powered_down), 14'h0001);
      check("true_off", true_current_out, 14'h0000);
      check("comp_off", complement_current_out, 14'h0000);
      sleep_driven = 1'b0;
      repeat (8) @(negedge clock);
      check("floating", code_t'(powered_down), 14'h0000);
      sleep_pin = 1'b0;
      sleep_driven = 1'b1;
      xfer(14'h0F0F);
   endtask
   task automatic results();
      if (err_count == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial begin
      repeat (3) @(negedge clock);
      rstn = 1'b1;
      check("reset_out", true_current_out, 14'h0000);
      repeat (2) @(negedge clock);
      foreach (codes[i]) xfer(codes[i]);
      test_stall();
      test_sleep();
      results();
   end
   initial begin
      #300000;
      err_count++;
      results();
   end
endmodule // testbench
